// >>> core/spc_standby_ctrl.v
// standby power-state controller: domain, ram, nvm and regulator choice
`timescale 1ns/100ps
`include "spc_defines.vh"
module spc_standby_ctrl #(
  parameter GROUPS   = 2,
  parameter PORTIONS = 8
) (
  input  wire                clk_i,
  input  wire                rst_n_i,
  input  wire [7:0]          s_axi_awaddr_i,
  input  wire                s_axi_awvalid_i,
  output wire                s_axi_awready_o,
  input  wire [31:0]         s_axi_wdata_i,
  input  wire [3:0]          s_axi_wstrb_i,
  input  wire                s_axi_wvalid_i,
  output wire                s_axi_wready_o,
  output wire [1:0]          s_axi_bresp_o,
  output wire                s_axi_bvalid_o,
  input  wire                s_axi_bready_i,
  input  wire [7:0]          s_axi_araddr_i,
  input  wire                s_axi_arvalid_i,
  output wire                s_axi_arready_o,
  output wire [31:0]         s_axi_rdata_o,
  output wire [1:0]          s_axi_rresp_o,
  output wire                s_axi_rvalid_o,
  input  wire                s_axi_rready_i,
  input  wire                wake_i,
  input  wire                domain_busy_i,
  input  wire                nvm_access_i,
  input  wire                sleepwalk_clk_i,
  input  wire                low_power_ref_ready_i,
  output reg                 domain_retain_o,
  output reg  [GROUPS-1:0]   ram_back_bias_o,
  output reg  [PORTIONS-1:0] sram_portion_on_o,
  output reg                 nvm_low_power_o,
  output reg                 main_reg_on_o,
  output reg                 lp_reg_on_o,
  output reg                 dma_sram_grant_o,
  output reg                 in_standby_o
);
  localparam ST_ACTIVE = 2'h0;
  localparam ST_ENTER  = 2'h1;
  localparam ST_STDBY  = 2'h2;
  localparam ST_WAKE   = 2'h3;
  localparam WAKE_CYC  = `SPC_WAKE_CYC;

  reg  [1:0]          state_q;
  reg  [1:0]          state_d;
  reg  [7:0]          wake_cnt_q;
  reg  [7:0]          wake_cnt_d;
  reg                 retained_q;
  reg                 retained_d;
  reg  [1:0]          dom_cfg_q;
  reg  [2*GROUPS-1:0] bias_q;
  reg                 sleep_req_q;
  reg                 reg_run_q;
  reg  [PORTIONS-1:0] sram_sw_q;
  reg  [31:0]         rd_data;
  reg                 rd_err;
  reg                 wr_err;

  wire                wr_en;
  wire [7:0]          wr_addr;
  wire [31:0]         wr_data;
  wire [3:0]          wr_strb;
  wire [7:0]          rd_addr;
  wire [GROUPS-1:0]   bias_w;
  wire [PORTIONS-1:0] portion_w;
  wire                standby;
  wire                retained;
  wire                bias_zero;
  wire                grant_d;

  ////////////////////////////////////////////////////////////////////////////
  // bus front end
  spc_axil_slave u_bus (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .awaddr_i  (s_axi_awaddr_i),
    .awvalid_i (s_axi_awvalid_i),
    .awready_o (s_axi_awready_o),
    .wdata_i   (s_axi_wdata_i),
    .wstrb_i   (s_axi_wstrb_i),
    .wvalid_i  (s_axi_wvalid_i),
    .wready_o  (s_axi_wready_o),
    .bresp_o   (s_axi_bresp_o),
    .bvalid_o  (s_axi_bvalid_o),
    .bready_i  (s_axi_bready_i),
    .araddr_i  (s_axi_araddr_i),
    .arvalid_i (s_axi_arvalid_i),
    .arready_o (s_axi_arready_o),
    .rdata_o   (s_axi_rdata_o),
    .rresp_o   (s_axi_rresp_o),
    .rvalid_o  (s_axi_rvalid_o),
    .rready_i  (s_axi_rready_i),
    .wr_en_o   (wr_en),
    .wr_addr_o (wr_addr),
    .wr_data_o (wr_data),
    .wr_strb_o (wr_strb),
    .wr_err_i  (wr_err),
    .rd_addr_o (rd_addr),
    .rd_data_i (rd_data),
    .rd_err_i  (rd_err)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register file
  // offsets that answer on the bus; anything else is refused with no store
  function reg_mapped;
    input [7:0] addr;
    begin
      case (addr)
        `SPC_OFF_STDBY_CFG:  reg_mapped = 1'b1;
        `SPC_OFF_SLEEP_CTRL: reg_mapped = 1'b1;
        `SPC_OFF_SRAM_SW:    reg_mapped = 1'b1;
        `SPC_OFF_STATUS:     reg_mapped = 1'b1;
        default:             reg_mapped = 1'b0;
      endcase
    end
  endfunction

  always @* begin
    wr_err = !reg_mapped(wr_addr);
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      dom_cfg_q   <= `SPC_DOM_AUTO;
      bias_q      <= {2*GROUPS{1'b0}};
      sleep_req_q <= 1'b0;
      reg_run_q   <= 1'b0;
      // every portion kept until software asks for less
      sram_sw_q   <= {PORTIONS{1'b1}};
    end else begin
      // every field sits in byte lane 0, so only that strobe is looked at
      if (wr_en && wr_strb[0]) begin
        case (wr_addr)
          `SPC_OFF_STDBY_CFG: begin
            dom_cfg_q <= wr_data[`SPC_CFG_DOM_LSB +: `SPC_CFG_DOM_W];
            bias_q    <= wr_data[`SPC_CFG_BIAS_LSB +: 2*GROUPS];
          end
          `SPC_OFF_SLEEP_CTRL: begin
            reg_run_q <= wr_data[`SPC_SLP_REGRUN_BIT];
          end
          `SPC_OFF_SRAM_SW: sram_sw_q <= wr_data[PORTIONS-1:0];
          default: ;
        endcase
      end
      // request wins in its own cycle; cleared once the wake completes
      if (wr_en && wr_strb[0] && wr_addr == `SPC_OFF_SLEEP_CTRL) begin
        sleep_req_q <= wr_data[`SPC_SLP_REQ_BIT];
      end else if (state_q == ST_WAKE && wake_cnt_q == 8'h00) begin
        sleep_req_q <= 1'b0;
      end
    end
  end

  always @* begin
    rd_data = 32'h0000_0000;
    rd_err  = !reg_mapped(rd_addr);
    case (rd_addr)
      `SPC_OFF_STDBY_CFG: begin
        rd_data[`SPC_CFG_DOM_LSB +: `SPC_CFG_DOM_W] = dom_cfg_q;
        rd_data[`SPC_CFG_BIAS_LSB +: 2*GROUPS]      = bias_q;
      end
      `SPC_OFF_SLEEP_CTRL: begin
        rd_data[`SPC_SLP_REQ_BIT]    = sleep_req_q;
        rd_data[`SPC_SLP_REGRUN_BIT] = reg_run_q;
      end
      `SPC_OFF_SRAM_SW: rd_data[PORTIONS-1:0] = sram_sw_q;
      `SPC_OFF_STATUS: begin
        rd_data[1:0] = state_q;
        rd_data[2]   = retained_q;
        rd_data[3]   = lp_reg_on_o;
        rd_data[4]   = main_reg_on_o;
        rd_data[5]   = dma_sram_grant_o;
      end
      default: ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sleep sequencer
  always @* begin
    state_d    = state_q;
    wake_cnt_d = wake_cnt_q;
    retained_d = retained_q;
    case (state_q)
      ST_ACTIVE: begin
        if (sleep_req_q) begin
          state_d = ST_ENTER;
        end
      end
      ST_ENTER: begin
        // activity is judged once, at entry; later traffic does not undo retention
        case (dom_cfg_q)
          `SPC_DOM_ACTIVE:   retained_d = 1'b0;
          `SPC_DOM_RETAIN:   retained_d = 1'b1;
          default:           retained_d = !domain_busy_i;
        endcase
        state_d = ST_STDBY;
      end
      ST_STDBY: begin
        // wake is a level, so one raised during entry is still seen here
        if (wake_i) begin
          state_d    = ST_WAKE;
          retained_d = 1'b0;
          wake_cnt_d = WAKE_CYC[7:0];
        end
      end
      ST_WAKE: begin
        // hold off access until supplies and ram bias settle
        if (wake_cnt_q == 8'h00) begin
          state_d = ST_ACTIVE;
        end else begin
          wake_cnt_d = wake_cnt_q - 8'h01;
        end
      end
      default: state_d = ST_ACTIVE;
    endcase
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q    <= ST_ACTIVE;
      wake_cnt_q <= 8'h00;
      retained_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      wake_cnt_q <= wake_cnt_d;
      retained_q <= retained_d;
    end
  end

  assign standby   = (state_q == ST_STDBY);
  assign retained  = standby && retained_q;
  assign bias_zero = (bias_q == {2*GROUPS{1'b0}});
  // access is given in active, and in standby when the domain is not retained and no bias field is set; none during the wake settle
  assign grant_d   = (state_q == ST_ACTIVE) ||
                     (standby && !retained_q && bias_zero);

  spc_ram_bias #(
    .GROUPS   (GROUPS),
    .PORTIONS (PORTIONS)
  ) u_bias (
    .bias_cfg_i   (bias_q),
    .standby_i    (standby),
    .retained_i   (retained),
    .sram_sw_i    (sram_sw_q),
    .back_bias_o  (bias_w),
    .portion_on_o (portion_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registered power outputs
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      domain_retain_o   <= 1'b0;
      ram_back_bias_o   <= {GROUPS{1'b0}};
      sram_portion_on_o <= {PORTIONS{1'b1}};
      nvm_low_power_o   <= 1'b0;
      // active mode runs from the main regulator
      main_reg_on_o     <= 1'b1;
      lp_reg_on_o       <= 1'b0;
      dma_sram_grant_o  <= 1'b0;
      in_standby_o      <= 1'b0;
    end else begin
      in_standby_o      <= standby;
      domain_retain_o   <= retained;
      ram_back_bias_o   <= bias_w;
      sram_portion_on_o <= portion_w;
      if (retained) begin
        nvm_low_power_o <= 1'b1;
        main_reg_on_o   <= reg_run_q;
      end else if (standby) begin
        nvm_low_power_o <= !nvm_access_i;
        main_reg_on_o   <= sleepwalk_clk_i;
      end else begin
        nvm_low_power_o <= 1'b0;
        main_reg_on_o   <= 1'b1;
      end
      // the low-power regulator counts as on only with its reference ready
      lp_reg_on_o      <= low_power_ref_ready_i;
      dma_sram_grant_o <= grant_d;
    end
  end
endmodule // spc_standby_ctrl

// >>> core/spc_defines.vh
// register offsets, field positions and reset values of the standby power-state control
`ifndef SPC_DEFINES_VH
`define SPC_DEFINES_VH

// byte offsets on the register bus
`define SPC_OFF_STDBY_CFG   8'h00
`define SPC_OFF_SLEEP_CTRL  8'h04
`define SPC_OFF_SRAM_SW     8'h08
`define SPC_OFF_STATUS      8'h0c

// standby_config_register fields
`define SPC_CFG_DOM_LSB     0
`define SPC_CFG_DOM_W       2
`define SPC_CFG_BIAS_LSB    4
`define SPC_CFG_BIAS_W      2
`define SPC_CFG_RST         32'h0000_0000

// domain_config_field encodings
`define SPC_DOM_AUTO        2'h0
`define SPC_DOM_ACTIVE      2'h1
`define SPC_DOM_RETAIN      2'h2

// ram_back_bias_field encodings
`define SPC_BIAS_NONE       2'h0
`define SPC_BIAS_RETAIN     2'h1
`define SPC_BIAS_STANDBY    2'h2
`define SPC_BIAS_OFF        2'h3

// sleep control fields
`define SPC_SLP_REQ_BIT     0
`define SPC_SLP_REGRUN_BIT  1

// sram switch reset: every portion retained
`define SPC_SRAM_SW_RST     8'hff

// axi response codes
`define SPC_RESP_OKAY       2'h0
`define SPC_RESP_SLVERR     2'h2

// wake settling time in ns and derived cycles at 4 ns
`define SPC_WAKE_NS         40
`define SPC_CLK_NS          4
`define SPC_WAKE_CYC        ((`SPC_WAKE_NS + `SPC_CLK_NS - 1) / `SPC_CLK_NS)

`endif

// >>> core/spc_axil_slave.v
// axi4-lite slave front end: one write and one read at a time
`timescale 1ns/100ps
`include "spc_defines.vh"
module spc_axil_slave (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire [7:0]  awaddr_i,
  input  wire        awvalid_i,
  output reg         awready_o,
  input  wire [31:0] wdata_i,
  input  wire [3:0]  wstrb_i,
  input  wire        wvalid_i,
  output reg         wready_o,
  output reg  [1:0]  bresp_o,
  output reg         bvalid_o,
  input  wire        bready_i,
  input  wire [7:0]  araddr_i,
  input  wire        arvalid_i,
  output reg         arready_o,
  output reg  [31:0] rdata_o,
  output reg  [1:0]  rresp_o,
  output reg         rvalid_o,
  input  wire        rready_i,
  output reg         wr_en_o,
  output reg  [7:0]  wr_addr_o,
  output reg  [31:0] wr_data_o,
  output reg  [3:0]  wr_strb_o,
  input  wire        wr_err_i,
  output wire [7:0]  rd_addr_o,
  input  wire [31:0] rd_data_i,
  input  wire        rd_err_i
);
  reg        aw_have_q;
  reg        w_have_q;
  reg  [7:0] araddr_q;

  assign rd_addr_o = araddr_q;

  ////////////////////////////////////////////////////////////////////////////
  // write: address and data taken in either order
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      awready_o <= 1'b1;
      wready_o  <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      bvalid_o  <= 1'b0;
      bresp_o   <= `SPC_RESP_OKAY;
      wr_en_o   <= 1'b0;
      wr_addr_o <= 8'h00;
      wr_data_o <= 32'h0000_0000;
      wr_strb_o <= 4'h0;
    end else begin
      wr_en_o <= 1'b0;
      if (awvalid_i && awready_o) begin
        wr_addr_o <= {awaddr_i[7:2], 2'b00};
        aw_have_q <= 1'b1;
        awready_o <= 1'b0;
      end
      if (wvalid_i && wready_o) begin
        wr_data_o <= wdata_i;
        wr_strb_o <= wstrb_i;
        w_have_q  <= 1'b1;
        wready_o  <= 1'b0;
      end
      if (aw_have_q && w_have_q && !bvalid_o && !wr_en_o) begin
        wr_en_o <= 1'b1;
      end
      if (wr_en_o) begin
        bvalid_o  <= 1'b1;
        bresp_o   <= wr_err_i ? `SPC_RESP_SLVERR : `SPC_RESP_OKAY;
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
      end
      if (bvalid_o && bready_i) begin
        bvalid_o  <= 1'b0;
        awready_o <= 1'b1;
        wready_o  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read: address taken, data one cycle later
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      arready_o <= 1'b1;
      araddr_q  <= 8'h00;
      rvalid_o  <= 1'b0;
      rdata_o   <= 32'h0000_0000;
      rresp_o   <= `SPC_RESP_OKAY;
    end else begin
      if (arvalid_i && arready_o) begin
        araddr_q  <= {araddr_i[7:2], 2'b00};
        arready_o <= 1'b0;
      end else if (!arready_o && !rvalid_o) begin
        rvalid_o <= 1'b1;
        rdata_o  <= rd_err_i ? 32'h0000_0000 : rd_data_i;
        rresp_o  <= rd_err_i ? `SPC_RESP_SLVERR : `SPC_RESP_OKAY;
      end
      if (rvalid_o && rready_i) begin
        rvalid_o  <= 1'b0;
        arready_o <= 1'b1;
      end
    end
  end
endmodule // spc_axil_slave

// >>> core/spc_ram_bias.v
// per ram group back-bias decision and sram portion retention
`timescale 1ns/100ps
`include "spc_defines.vh"
module spc_ram_bias #(
  parameter GROUPS   = 2,
  parameter PORTIONS = 8
) (
  input  wire [2*GROUPS-1:0] bias_cfg_i,
  input  wire                standby_i,
  input  wire                retained_i,
  input  wire [PORTIONS-1:0] sram_sw_i,
  output wire [GROUPS-1:0]   back_bias_o,
  output wire [PORTIONS-1:0] portion_on_o
);
  function bias_on;
    input [1:0] f;
    input       stby;
    input       ret;
    begin
      case (f)
        `SPC_BIAS_NONE:    bias_on = stby & ret;
        `SPC_BIAS_RETAIN:  bias_on = stby & ret;
        `SPC_BIAS_STANDBY: bias_on = stby;
        default:            bias_on = 1'b0;
      endcase
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < GROUPS; g = g + 1) begin : g_grp
      assign back_bias_o[g] = bias_on(bias_cfg_i[2*g+1:2*g], standby_i, retained_i);
    end
  endgenerate

  // portions with their switch clear lose power in standby only
  assign portion_on_o = standby_i ? sram_sw_i : {PORTIONS{1'b1}};
endmodule // spc_ram_bias

// >>> tb/spc_standby_asserts.sv
// concurrent checks on the standby power-state control ports
`timescale 1ns/100ps
module spc_standby_asserts #(
  parameter GROUPS   = 2,
  parameter PORTIONS = 8
) (
  input wire logic              clk_i,
  input wire logic              rst_n_i,
  input wire logic              s_axi_awvalid_i,
  input wire logic              s_axi_awready_o,
  input wire logic              s_axi_wvalid_i,
  input wire logic              s_axi_wready_o,
  input wire logic              s_axi_bvalid_o,
  input wire logic              s_axi_bready_i,
  input wire logic              s_axi_arvalid_i,
  input wire logic              s_axi_arready_o,
  input wire logic              s_axi_rvalid_o,
  input wire logic              nvm_access_i,
  input wire logic              sleepwalk_clk_i,
  input wire logic              low_power_ref_ready_i,
  input wire logic              domain_retain_o,
  input wire logic [GROUPS-1:0] ram_back_bias_o,
  input wire logic              nvm_low_power_o,
  input wire logic              main_reg_on_o,
  input wire logic              lp_reg_on_o,
  input wire logic              dma_sram_grant_o,
  input wire logic              in_standby_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////
  grant_clean_a: assert property (dma_sram_grant_o |->
    !domain_retain_o && ram_back_bias_o == '0) else $error("grant with retained state");
  grant_retain_a: assert property (in_standby_o && domain_retain_o |->
    !dma_sram_grant_o) else $error("grant while domain retained");
  lp_ref_a: assert property (lp_reg_on_o |-> $past(low_power_ref_ready_i))
    else $error("low-power regulator on before reference ready");
  nvm_auto_a: assert property ((in_standby_o && !domain_retain_o && !nvm_access_i) [*3]
    |-> nvm_low_power_o) else $error("idle nvm not in low power");
  retain_nvm_a: assert property (in_standby_o && domain_retain_o |->
    nvm_low_power_o) else $error("nvm not low power in retention");
  walk_main_a: assert property ((in_standby_o && !domain_retain_o && sleepwalk_clk_i) [*2]
    |-> main_reg_on_o) else $error("main regulator off while sleepwalking");
  wr_resp_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
    && s_axi_wready_o |-> ##[1:3] s_axi_bvalid_o) else $error("write response late");
  rd_resp_a: assert property (s_axi_arvalid_i && s_axi_arready_o |-> ##2 s_axi_rvalid_o)
    else $error("read response late");
  b_close_a: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("write response not released");
  c_ret: cover property (in_standby_o && domain_retain_o);
  c_act: cover property (in_standby_o && dma_sram_grant_o);
  c_wake: cover property ($fell(in_standby_o));
endmodule // spc_standby_asserts

bind spc_standby_ctrl spc_standby_asserts #(.GROUPS(GROUPS), .PORTIONS(PORTIONS))
  spc_standby_asserts_inst (.clk_i, .rst_n_i, .s_axi_awvalid_i, .s_axi_awready_o,
  .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i,
  .s_axi_arready_o, .s_axi_rvalid_o, .nvm_access_i, .sleepwalk_clk_i,
  .low_power_ref_ready_i, .domain_retain_o, .ram_back_bias_o, .nvm_low_power_o,
  .main_reg_on_o, .lp_reg_on_o, .dma_sram_grant_o, .in_standby_o);

// >>> tb/spc_power_plant.sv
// far-side model: domain activity, nvm traffic, sleepwalk clocks, reference
`timescale 1ns/100ps
module spc_power_plant #(
  parameter REF_DLY = 6
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic busy_en_i,
  input  wire logic nvm_en_i,
  input  wire logic walk_en_i,
  input  wire logic ref_en_i,
  output logic      domain_busy_o,
  output logic      nvm_access_o,
  output logic      sleepwalk_clk_o,
  output logic      low_power_ref_ready_o
);
  logic [3:0] ref_cnt_q;
  logic [1:0] nvm_cnt_q;
  ////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      ref_cnt_q <= 4'h0;
      nvm_cnt_q <= 2'h0;
      domain_busy_o <= 1'b0;
      nvm_access_o <= 1'b0;
      sleepwalk_clk_o <= 1'b0;
      low_power_ref_ready_o <= 1'b0;
    end else begin
      domain_busy_o <= busy_en_i;
      sleepwalk_clk_o <= walk_en_i;
      nvm_cnt_q <= nvm_cnt_q + 2'h1;
      // sparse traffic leaves idle gaps for the low-power decision
      nvm_access_o <= nvm_en_i && (nvm_cnt_q == 2'h0);
      if (!ref_en_i)
        ref_cnt_q <= 4'h0;
      else if (ref_cnt_q != 4'(REF_DLY))
        ref_cnt_q <= ref_cnt_q + 4'h1;
      // reference needs settling time before it reports ready
      low_power_ref_ready_o <= ref_en_i && (ref_cnt_q == 4'(REF_DLY));
    end
  end
endmodule // spc_power_plant

// >>> tb/testbench.sv
// self-checking bench of the standby power-state control
`timescale 1ns/100ps
`include "spc_defines.vh"
module testbench;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic [3:0]  s_axi_wstrb_i = 4'h0;
  logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, wake_i = 1'b0;
  logic        busy_en = 1'b0, nvm_en = 1'b0, walk_en = 1'b0, ref_en = 1'b1;
  wire         s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  wire         s_axi_rvalid_o, domain_busy_i, nvm_access_i, sleepwalk_clk_i;
  wire         low_power_ref_ready_i, domain_retain_o, nvm_low_power_o, main_reg_on_o;
  wire         lp_reg_on_o, dma_sram_grant_o, in_standby_o;
  wire [1:0]   s_axi_bresp_o, s_axi_rresp_o, ram_back_bias_o;
  wire [31:0]  s_axi_rdata_o;
  wire [7:0]   sram_portion_on_o;
  int          n_fail = 0, checks = 0, cyc = 0;
  spc_standby_ctrl #(.GROUPS(2), .PORTIONS(8)) spc_standby_ctrl_inst (.clk_i, .rst_n_i,
    .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
    .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i, .wake_i, .domain_busy_i, .nvm_access_i,
    .sleepwalk_clk_i, .low_power_ref_ready_i, .domain_retain_o, .ram_back_bias_o,
    .sram_portion_on_o, .nvm_low_power_o, .main_reg_on_o, .lp_reg_on_o,
    .dma_sram_grant_o, .in_standby_o);
  spc_power_plant spc_power_plant_inst (.clk_i, .rst_n_i, .busy_en_i(busy_en),
    .nvm_en_i(nvm_en), .walk_en_i(walk_en), .ref_en_i(ref_en),
    .domain_busy_o(domain_busy_i), .nvm_access_o(nvm_access_i),
    .sleepwalk_clk_o(sleepwalk_clk_i), .low_power_ref_ready_o(low_power_ref_ready_i));
  ////////////////////////////////////////////////////////////
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      conclude();
    end
  end
  task automatic conclude();
    if (n_fail == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_wstrb_i <= 4'hf;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awvalid_i && s_axi_awready_o === 1'b1)
        s_axi_awvalid_i <= 1'b0;
      if (s_axi_wvalid_i && s_axi_wready_o === 1'b1)
        s_axi_wvalid_i <= 1'b0;
    end while (s_axi_bvalid_o !== 1'b1);
    s_axi_bready_i <= 1'b0;
    chk("bresp", 32'(er), 32'(s_axi_bresp_o));
    @(posedge clk_i);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arvalid_i && s_axi_arready_o === 1'b1)
        s_axi_arvalid_i <= 1'b0;
    end while (s_axi_rvalid_o !== 1'b1);
    s_axi_rready_i <= 1'b0;
    chk("rresp", 32'(er), 32'(s_axi_rresp_o));
    chk("rdata", exp, s_axi_rdata_o);
    @(posedge clk_i);
  endtask
  task automatic wait_sb(input logic want);
    do
      @(posedge clk_i);
    while (in_standby_o !== want);
  endtask
  // one standby round trip: enter, judge the standby state, wake, judge recovery
  task automatic stby(input logic [7:0] cfg, input logic [1:0] slp, input logic busy,
                      input logic [7:0] sw);
    logic       ret;
    logic [1:0] bb;
    ret = (cfg[1:0] == 2'h2) || (cfg[1:0] == 2'h0 && !busy);
    for (int g = 0; g < 2; g++)
      bb[g] = (cfg[4+2*g+:2] == 2'h2) || (cfg[4+2*g+:2] < 2'h2 && ret);
    busy_en <= busy;
    axi_wr(8'h00, 32'(cfg), `SPC_RESP_OKAY);
    axi_wr(8'h08, 32'(sw), `SPC_RESP_OKAY);
    axi_wr(8'h04, 32'(slp), `SPC_RESP_OKAY);
    wait_sb(1'b1);
    repeat (3) @(posedge clk_i);
    chk("retain", 32'(ret), 32'(domain_retain_o));
    chk("bias", 32'(bb), 32'(ram_back_bias_o));
    chk("grant", 32'(!ret && cfg[7:4] == 4'h0), 32'(dma_sram_grant_o));
    chk("lp_reg", 32'(ref_en), 32'(lp_reg_on_o));
    if (ret) begin
      chk("nvm_lp", 32'h1, 32'(nvm_low_power_o));
      chk("main", 32'(slp[1]), 32'(main_reg_on_o));
      chk("portion", 32'(sw), 32'(sram_portion_on_o));
    end else begin
      chk("main", 32'(walk_en), 32'(main_reg_on_o));
      if (!nvm_en)
        chk("nvm_lp", 32'h1, 32'(nvm_low_power_o));
    end
    wake_i <= 1'b1;
    wait_sb(1'b0);
    wake_i <= 1'b0;
    repeat (`SPC_WAKE_CYC + 3) @(posedge clk_i);
    chk("woken", 32'h1, 32'({domain_retain_o, ram_back_bias_o, dma_sram_grant_o}));
    chk("portion", 32'hff, 32'(sram_portion_on_o));
    axi_rd(8'h04, 32'(slp & 2'h2), `SPC_RESP_OKAY);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_regs();
    axi_rd(8'h00, 32'h0, `SPC_RESP_OKAY);
    axi_rd(8'h08, 32'hff, `SPC_RESP_OKAY);
    axi_rd(8'h10, 32'h0, `SPC_RESP_SLVERR);
    axi_wr(8'h10, 32'hff, `SPC_RESP_SLVERR);
  endtask
  task automatic t_modes();
    for (int pd = 0; pd < 3; pd++)
      for (int b = 0; b < 2; b++)
        stby(8'(pd), 2'h1, b[0], 8'hff);
  endtask
  task automatic t_bias();
    logic [7:0] tbl [4];
    tbl = '{8'hb1, 8'h72, 8'hc2, 8'h21};
    foreach (tbl[i])
      stby(tbl[i], 2'h1, 1'b0, 8'hff);
  endtask
  task automatic t_regul();
    walk_en <= 1'b1;
    nvm_en <= 1'b1;
    stby(8'h01, 2'h1, 1'b0, 8'hff);
    walk_en <= 1'b0;
    nvm_en <= 1'b0;
    stby(8'h02, 2'h3, 1'b0, 8'hff);
    ref_en <= 1'b0;
    stby(8'h02, 2'h1, 1'b0, 8'hff);
    ref_en <= 1'b1;
    repeat (10) @(posedge clk_i);
  endtask
  task automatic t_sram();
    stby(8'h02, 2'h1, 1'b0, 8'h5a);
    stby(8'h00, 2'h1, 1'b0, 8'ha5);
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    t_regs();
    t_modes();
    t_bias();
    t_regul();
    t_sram();
    conclude();
  end
endmodule // testbench
